/* verilog/uart_lin_top.v */
/*
 * uart with lin header extension behind an axi4-lite slave.
 * assumes an axi4-lite master on clock, a lin transceiver joining
 * tx_pin and rx_pin to the single wire, and rx_pin asynchronous.
 */
`timescale 1ns/1ps
`include "uart_lin_defs.vh"
module uart_lin_top #(
    parameter AW    = 18,
    parameter FIFO_AW = 2
) (
    // clock and reset
    input  wire          clock,
    input  wire          srst,
    // axi4-lite write address and data
    input  wire          awvalid,
    output wire          awready,
    input  wire [AW-1:0] awaddr,
    input  wire          wvalid,
    output wire          wready,
    input  wire [31:0]   wdata,
    input  wire [3:0]    wstrb,
    // axi4-lite write response
    output reg           bvalid_q,
    input  wire          bready,
    output reg  [1:0]    bresp_q,
    // axi4-lite read
    input  wire          arvalid,
    output wire          arready,
    input  wire [AW-1:0] araddr,
    output reg           rvalid_q,
    input  wire          rready,
    output reg  [31:0]   rdata_q,
    output reg  [1:0]    rresp_q,
    // serial line
    input  wire          rx_pin,
    output reg           tx_pin_q,
    // tx done event, gated by its enable
    output wire          tx_done_irq
);
    localparam T_IDLE = 5'b00001, T_LOAD = 5'b00010, T_DATA = 5'b00100;
    localparam T_BRK  = 5'b01000, T_DLM  = 5'b10000;
    localparam R_IDLE = 4'b0001, R_START = 4'b0010, R_DATA = 4'b0100, R_STOP = 4'b1000;
    localparam S_IDLE = 5'b00001, S_LOW = 5'b00010, S_WRISE = 5'b00100;
    localparam S_WFALL = 5'b01000, S_MEAS = 5'b10000;

    function [2:0] reg_sel;
        input [AW-1:0] a;
        begin
            if (a[1:0] != 2'h0)
                reg_sel = `SEL_NONE;
            else if (a[AW-1:2] == `IDX_DATA)
                reg_sel = `SEL_DATA;
            else if (a[AW-1:2] == `IDX_IRQ)
                reg_sel = `SEL_IRQ;
            else if (a[AW-1:2] == `IDX_LIN)
                reg_sel = `SEL_LIN;
            else if (a[AW-1:2] == `IDX_BAUD)
                reg_sel = `SEL_BAUD;
            else if (a[AW-1:2] == `IDX_STAT)
                reg_sel = `SEL_STAT;
            else
                reg_sel = `SEL_NONE;
        end
    endfunction

    // registers
    reg        ti_q, tien_q, brk_flag_q, syn_flag_q;
    reg        lin_en_q, ms_q, asu_q, message_auto_sync_update_q, sbk_q, brk_sent_q;
    reg [2:0]  bl_q;
    reg [15:0] baud_q;
    // bus state
    reg          aw_have_q, w_have_q, rd_stg_q, rd_pop_q;
    reg [AW-1:0] awaddr_q, rd_addr_q;
    reg [31:0]   wdata_q;
    reg [3:0]    wstrb_q;
    // line engines
    reg [4:0]  tx_st_q;
    reg [3:0]  rx_st_q;
    reg [4:0]  sy_st_q;
    reg [15:0] tx_cnt_q, rx_cnt_q;
    reg [4:0]  tx_bits_q;
    reg [3:0]  rx_bits_q;
    reg [8:0]  tx_sh_q;
    reg [7:0]  rx_sh_q;
    reg [19:0] sy_cnt_q;
    reg [2:0]  falls_q;
    reg        rx_m_q, rx_s_q, rx_p_q;

    wire [7:0]  tx_dout, rx_dout;
    wire        tx_full, tx_empty, rx_full, rx_empty;
    wire [2:0]  wsel = reg_sel(awaddr_q);
    wire [2:0]  rsel = reg_sel(rd_addr_q);
    wire        wr_go = aw_have_q && w_have_q && !bvalid_q;
    wire        ar_hs = arvalid && arready;
    wire        lane0 = wr_go && wstrb_q[0];
    wire        tx_push = lane0 && (wsel == `SEL_DATA) && !tx_full;
    wire        rx_pop = ar_hs && (reg_sel(araddr) == `SEL_DATA) && !rx_empty;
    wire        tx_tick = (tx_cnt_q == 16'h0000);
    wire        rx_tick = (rx_cnt_q == 16'h0000);
    wire [15:0] baud_m1 = baud_q - 16'h0001;
    wire        fall = rx_p_q && !rx_s_q;
    wire        lin_slave = lin_en_q && !ms_q;
    wire        brk_req = sbk_q && lin_en_q && ms_q && !brk_sent_q;
    wire        tx_pop = (tx_st_q == T_IDLE) && !brk_req && !tx_empty;
    wire        tx_byte_done = (tx_st_q == T_DATA) && tx_tick && (tx_bits_q == 5'h01);
    wire        rx_push = (rx_st_q == R_STOP) && rx_tick && rx_s_q && !rx_full;
    wire        rx_gate = (sy_st_q == S_WRISE) || (sy_st_q == S_WFALL) || (sy_st_q == S_MEAS);
    wire [19:0] brk_thr = {4'h0, baud_q} * `BRK_DET_BITS;
    wire [19:0] sy_div = (sy_cnt_q + 20'h00001) >> `SYNC_SHIFT;
    wire        sy_done = (sy_st_q == S_MEAS) && fall && (falls_q == `SYNC_FALLS);
    wire        sy_ok = sy_done && (sy_div != 20'h00000) && (sy_div[19:16] == 4'h0);
    wire        sy_load = sy_ok && (asu_q || message_auto_sync_update_q);
    wire        ti_set = tx_byte_done && tx_empty;
    wire        brk_set = tx_byte_done && brk_sent_q;

    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign arready = !rd_stg_q && !rvalid_q;
    assign tx_done_irq = ti_q && tien_q;

    uart_fifo #(.W(8), .AW(FIFO_AW)) u_txq (
        .clock (clock),
        .srst  (srst),
        .push  (tx_push),
        .din   (wdata_q[7:0]),
        .full  (tx_full),
        .pop   (tx_pop),
        .dout_q(tx_dout),
        .empty (tx_empty)
    );

    uart_fifo #(.W(8), .AW(FIFO_AW)) u_rxq (
        .clock (clock),
        .srst  (srst),
        .push  (rx_push),
        .din   (rx_sh_q),
        .full  (rx_full),
        .pop   (rx_pop),
        .dout_q(rx_dout),
        .empty (rx_empty)
    );

    // axi write channel and register writes
    always @(posedge clock) begin
        if (srst) begin
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            awaddr_q   <= {AW{1'b0}};
            wdata_q    <= 32'h00000000;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= `RESP_OKAY;
            ti_q       <= 1'b0;
            tien_q     <= 1'b0;
            lin_en_q   <= 1'b0;
            ms_q       <= 1'b0;
            asu_q      <= 1'b0;
            message_auto_sync_update_q     <= 1'b0;
            sbk_q      <= 1'b0;
            bl_q       <= 3'h0;
            baud_q     <= `BAUD_DIV_RST;
            brk_flag_q <= 1'b0;
            syn_flag_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
            if (lane0 && (wsel == `SEL_IRQ)) begin
                tien_q <= wdata_q[`TI_BIT];
                if (!wdata_q[`TI_BIT]) begin
                    ti_q <= 1'b0;
                end
            end
            if (ti_set) begin
                ti_q <= 1'b1;
            end
            if (lane0 && (wsel == `SEL_LIN)) begin
                lin_en_q <= wdata_q[`LIN_EN_BIT];
                if (!lin_en_q) begin
                    ms_q <= wdata_q[`LIN_MS_BIT];
                end
                asu_q  <= wdata_q[`LIN_ASU_BIT];
                message_auto_sync_update_q <= wdata_q[`LIN_MESSAGE_AUTO_SYNC_UPDATE_BIT];
                sbk_q  <= wdata_q[`LIN_SBK_BIT];
                bl_q   <= wdata_q[`LIN_BL_HI:`LIN_BL_LO];
            end else begin
                if (brk_set) begin
                    sbk_q <= 1'b0;
                end
                if (sy_load) begin
                    message_auto_sync_update_q <= 1'b0;
                end
            end
            if (wr_go && (wsel == `SEL_BAUD)) begin
                if (wstrb_q[0]) begin
                    baud_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    baud_q[15:8] <= wdata_q[15:8];
                end
            end
            if (sy_load) begin
                baud_q <= sy_div[15:0];
            end
            if (lane0 && (wsel == `SEL_STAT)) begin
                if (!wdata_q[`ST_BRK_BIT]) begin
                    brk_flag_q <= 1'b0;
                end
                if (!wdata_q[`ST_SYN_BIT]) begin
                    syn_flag_q <= 1'b0;
                end
            end
            if (brk_set) begin
                brk_flag_q <= 1'b1;
            end
            if (sy_ok) begin
                syn_flag_q <= 1'b1;
            end
        end
    end

    // axi read channel: pop or select, then answer
    always @(posedge clock) begin
        if (srst) begin
            rd_stg_q  <= 1'b0;
            rd_pop_q  <= 1'b0;
            rd_addr_q <= {AW{1'b0}};
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RESP_OKAY;
        end else begin
            if (ar_hs) begin
                rd_stg_q  <= 1'b1;
                rd_pop_q  <= rx_pop;
                rd_addr_q <= araddr;
            end
            if (rd_stg_q) begin
                rd_stg_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q  <= `RESP_OKAY;
                rdata_q  <= 32'h00000000;
                if (rsel == `SEL_DATA) begin
                    rdata_q[7:0] <= rd_pop_q ? rx_dout : `RST_BYTE;
                end else if (rsel == `SEL_IRQ) begin
                    rdata_q[`TI_BIT] <= ti_q;
                end else if (rsel == `SEL_LIN) begin
                    rdata_q[7:0] <= {lin_en_q, ms_q, asu_q, message_auto_sync_update_q, sbk_q, bl_q};
                end else if (rsel == `SEL_BAUD) begin
                    rdata_q[15:0] <= baud_q;
                end else if (rsel == `SEL_STAT) begin
                    rdata_q[3:0] <= {syn_flag_q, brk_flag_q, tx_full, rx_empty};
                end else begin
                    rresp_q <= `RESP_SLVERR;
                end
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // transmitter: queued bytes, and break plus delimiter in master mode
    always @(posedge clock) begin
        if (srst) begin
            tx_st_q    <= T_IDLE;
            tx_cnt_q   <= 16'h0000;
            tx_bits_q  <= 5'h00;
            tx_sh_q    <= 9'h1FF;
            tx_pin_q   <= 1'b1;
            brk_sent_q <= 1'b0;
        end else begin
            tx_cnt_q <= tx_tick ? baud_m1 : tx_cnt_q - 16'h0001;
            if (!sbk_q) begin
                brk_sent_q <= 1'b0;
            end
            case (tx_st_q)
                T_IDLE: begin
                    tx_pin_q <= 1'b1;
                    tx_cnt_q <= baud_m1;
                    if (brk_req) begin
                        tx_st_q   <= T_BRK;
                        tx_pin_q  <= 1'b0;
                        tx_bits_q <= `BRK_BASE + {2'h0, bl_q};
                    end else if (!tx_empty) begin
                        tx_st_q <= T_LOAD;
                    end
                end
                T_LOAD: begin
                    tx_st_q   <= T_DATA;
                    tx_pin_q  <= 1'b0;
                    tx_sh_q   <= {1'b1, tx_dout};
                    tx_bits_q <= {1'b0, `FRAME_BITS};
                    tx_cnt_q  <= baud_m1;
                end
                T_DATA: begin
                    if (tx_tick) begin
                        tx_pin_q  <= tx_sh_q[0];
                        tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
                        tx_bits_q <= tx_bits_q - 5'h01;
                        if (tx_bits_q == 5'h01) begin
                            tx_st_q  <= T_IDLE;
                            tx_pin_q <= 1'b1;
                        end
                    end
                end
                T_BRK: begin
                    if (tx_tick) begin
                        tx_bits_q <= tx_bits_q - 5'h01;
                        if (tx_bits_q == 5'h01) begin
                            tx_st_q  <= T_DLM;
                            tx_pin_q <= 1'b1;
                        end
                    end
                end
                T_DLM: begin
                    if (tx_tick) begin
                        tx_st_q    <= T_IDLE;
                        brk_sent_q <= 1'b1;
                    end
                end
                default: tx_st_q <= T_IDLE;
            endcase
        end
    end

    // receiver: 8n1, bytes with a bad stop bit are dropped
    always @(posedge clock) begin
        if (srst) begin
            rx_m_q    <= 1'b1;
            rx_s_q    <= 1'b1;
            rx_p_q    <= 1'b1;
            rx_st_q   <= R_IDLE;
            rx_cnt_q  <= 16'h0000;
            rx_bits_q <= 4'h0;
            rx_sh_q   <= 8'h00;
        end else begin
            rx_m_q   <= rx_pin;
            rx_s_q   <= rx_m_q;
            rx_p_q   <= rx_s_q;
            rx_cnt_q <= rx_tick ? baud_m1 : rx_cnt_q - 16'h0001;
            case (rx_st_q)
                R_IDLE: begin
                    if (fall && !rx_gate) begin
                        rx_st_q  <= R_START;
                        rx_cnt_q <= baud_q >> 1;
                    end
                end
                R_START: begin
                    if (rx_tick) begin
                        rx_st_q   <= rx_s_q ? R_IDLE : R_DATA;
                        rx_bits_q <= `DATA_BITS;
                    end
                end
                R_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q   <= {rx_s_q, rx_sh_q[7:1]};
                        rx_bits_q <= rx_bits_q - 4'h1;
                        if (rx_bits_q == 4'h1) begin
                            rx_st_q <= R_STOP;
                        end
                    end
                end
                R_STOP: begin
                    if (rx_tick) begin
                        rx_st_q <= R_IDLE;
                    end
                end
                default: rx_st_q <= R_IDLE;
            endcase
        end
    end

    // slave header: break detection, then sync field measurement
    always @(posedge clock) begin
        if (srst) begin
            sy_st_q  <= S_IDLE;
            sy_cnt_q <= 20'h00000;
            falls_q  <= 3'h0;
        end else if (!lin_slave) begin
            sy_st_q <= S_IDLE;
        end else begin
            case (sy_st_q)
                S_IDLE: begin
                    sy_cnt_q <= 20'h00001;
                    if (!rx_s_q) begin
                        sy_st_q <= S_LOW;
                    end
                end
                S_LOW: begin
                    sy_cnt_q <= sy_cnt_q + 20'h00001;
                    if (rx_s_q) begin
                        sy_st_q <= S_IDLE;
                    end else if (sy_cnt_q >= brk_thr) begin
                        sy_st_q <= S_WRISE;
                    end
                end
                S_WRISE: begin
                    if (rx_s_q) begin
                        sy_st_q <= S_WFALL;
                    end
                end
                S_WFALL: begin
                    sy_cnt_q <= 20'h00000;
                    falls_q  <= 3'h0;
                    if (fall) begin
                        sy_st_q <= S_MEAS;
                    end
                end
                S_MEAS: begin
                    sy_cnt_q <= sy_cnt_q + 20'h00001;
                    if (fall) begin
                        falls_q <= falls_q + 3'h1;
                    end
                    if (sy_done || (sy_cnt_q == 20'hFFFFF)) begin
                        sy_st_q <= S_IDLE;
                    end
                end
                default: sy_st_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* verilog/uart_lin_defs.vh */
/*
 * register indices, field positions, reset values and timing figures
 * of the uart with lin extension; included by uart_lin_top and the bench.
 */
`ifndef UART_LIN_DEFS_VH
`define UART_LIN_DEFS_VH

// register indices; byte address is four times the index
`define IDX_DATA      16'h00A6
`define IDX_IRQ       16'h00A7
`define IDX_LIN       16'hA090
`define IDX_BAUD      16'h00A8
`define IDX_STAT      16'h00A9

// register select codes
`define SEL_NONE      3'h0
`define SEL_DATA      3'h1
`define SEL_IRQ       3'h2
`define SEL_LIN       3'h3
`define SEL_BAUD      3'h4
`define SEL_STAT      3'h5

// irq status/enable field
`define TI_BIT        0

// lin control/status fields
`define LIN_EN_BIT    7
`define LIN_MS_BIT    6
`define LIN_ASU_BIT   5
`define LIN_MESSAGE_AUTO_SYNC_UPDATE_BIT  4
`define LIN_SBK_BIT   3
`define LIN_BL_HI     2
`define LIN_BL_LO     0

// own status fields
`define ST_RXE_BIT    0
`define ST_TXF_BIT    1
`define ST_BRK_BIT    2
`define ST_SYN_BIT    3

// reset values
`define RST_BYTE      8'h00
`define BAUD_DIV_RST  16'h0010

// frame timing in bit times
`define FRAME_BITS    4'hA
`define DATA_BITS     4'h8
`define BRK_BASE      5'h0D
`define BRK_DET_BITS  20'h0000B
`define SYNC_FALLS    3'h3
`define SYNC_SHIFT    3

// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* verilog/uart_fifo.v */
/*
 * small synchronous fifo; read data come out of a register loaded on pop.
 * assumes push is never asserted while full nor pop while empty.
 */
`timescale 1ns/1ps
module uart_fifo #(
    parameter W     = 8,
    parameter AW    = 2
) (
    // clock and reset
    input  wire         clock,
    input  wire         srst,
    // fill side
    input  wire         push,
    input  wire [W-1:0] din,
    output wire         full,
    // drain side
    input  wire         pop,
    output reg  [W-1:0] dout_q,
    output wire         empty
);
    reg [W-1:0] mem [0:(1<<AW)-1];
    reg [AW:0]  wp_q;
    reg [AW:0]  rp_q;

    assign empty = (wp_q == rp_q);
    assign full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);

    always @(posedge clock) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= din;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            wp_q   <= {(AW+1){1'b0}};
            rp_q   <= {(AW+1){1'b0}};
            dout_q <= {W{1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                dout_q <= mem[rp_q[AW-1:0]];
                rp_q   <= rp_q + 1'b1;
            end
        end
    end
endmodule

/* tb/uart_lin_sva.sv */
/*
 * port checker for uart_lin_top: bus handshakes, tx done event, line.
 * assumes one clock domain with srst as synchronous reset.
 */
`timescale 1ns/1ps
module uart_lin_sva (
    // clock and reset
    input wire clock,
    input wire srst,
    // write channels
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid_q,
    input wire bready,
    // read channels
    input wire arvalid,
    input wire arready,
    input wire rvalid_q,
    input wire rready,
    // line and event
    input wire tx_pin_q,
    input wire tx_done_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_rd_ans;
        (!arready && !rvalid_q) ##1 rvalid_q;
    endsequence
    sequence s_wr_ans;
        (!awready && !bvalid_q) ##1 bvalid_q;
    endsequence
    property p_rd_lat; arvalid && arready |=> s_rd_ans; endproperty
    property p_wr_lat; awvalid && awready && wvalid && wready |=> s_wr_ans; endproperty
    property p_b_done; bvalid_q && bready |=> !bvalid_q && awready && wready; endproperty
    property p_r_done; rvalid_q && rready |=> !rvalid_q && arready; endproperty
    property p_b_busy; bvalid_q |-> !awready && !wready; endproperty
    property p_r_busy; rvalid_q |-> !arready; endproperty
    property p_irq_clr; $fell(tx_done_irq) |-> $rose(bvalid_q); endproperty
    property p_irq_idle; $rose(tx_done_irq) |-> tx_pin_q; endproperty
    property p_start_bit; $fell(tx_pin_q) |=> !tx_pin_q [*7]; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer not two edges after address");
    a_wr_lat: assert property (p_wr_lat)
        else $error("write answer not two edges after address");
    a_b_done: assert property (p_b_done)
        else $error("write response did not end");
    a_r_done: assert property (p_r_done)
        else $error("read response did not end");
    a_b_busy: assert property (p_b_busy)
        else $error("write taken during response");
    a_r_busy: assert property (p_r_busy)
        else $error("read taken during response");
    a_irq_clr: assert property (p_irq_clr)
        else $error("tx done event dropped without a write");
    a_irq_idle: assert property (p_irq_idle)
        else $error("tx done event while line busy");
    a_start_bit: assert property (p_start_bit)
        else $error("start bit too short");
endmodule

bind uart_lin_top uart_lin_sva chk_u (.clock, .srst, .awvalid, .awready, .wvalid, .wready,
    .bvalid_q, .bready, .arvalid, .arready, .rvalid_q, .rready, .tx_pin_q, .tx_done_irq);

/* tb/lin_node_model.sv */
/*
 * other lin node: sends bytes and headers, records bytes and breaks seen.
 * assumes 8n1 framing at BIT clocks per bit and a line idling high.
 */
`timescale 1ns/1ps
module lin_node_model #(
    parameter BIT = 16
) (
    input  wire  clock,
    input  wire  line_in,
    output logic line_out
);
    logic [7:0] got_q[$];
    logic [8:0] b;
    int         brk_n = 0;
    initial line_out = 1'b1;
    task tx_byte(input [7:0] v);
        for (int i = 0; i < 10; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i-1];
            repeat (BIT) @(posedge clock);
        end
    endtask
    // break, delimiter, sync byte, then pid byte
    task tx_header(input [7:0] pid);
        line_out <= 1'b0;
        repeat (13 * BIT) @(posedge clock);
        line_out <= 1'b1;
        repeat (BIT) @(posedge clock);
        tx_byte(8'h55);
        tx_byte(pid);
    endtask
    // mid-bit sampling; a low stop bit counts as a break
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clock);
            b[i] = line_in;
        end
        if (b[8]) got_q.push_back(b[7:0]);
        else begin
            brk_n++;
            wait (line_in);
        end
    end
endmodule

/* tb/uart_lin_extension_tb.sv */
/*
 * self-checking bench for uart_lin_top with a lin node on the line.
 * assumes the register map of uart_lin_defs.vh and 16 clocks per bit.
 */
`timescale 1ns/1ps
`include "uart_lin_defs.vh"
module uart_lin_extension_tb;
    logic        clock, srst, awvalid, wvalid, bvalid_q, bready, arvalid, rvalid_q;
    logic        rready, awready, wready, arready, rx_pin, tx_pin_q, tx_done_irq;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata_q, rd;
    logic [1:0]  bresp_q, rresp_q;
    logic [7:0]  v;
    logic [7:0]  exp_q[$];
    int          mismatches = 0, checks_done = 0, seed = 23, n;
    uart_lin_top dut_u (.clock, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb(4'hF), .bvalid_q, .bready, .bresp_q, .arvalid, .arready, .araddr,
        .rvalid_q, .rready, .rdata_q, .rresp_q, .rx_pin, .tx_pin_q, .tx_done_irq);
    lin_node_model nd_u (.clock, .line_in(tx_pin_q), .line_out(rx_pin));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task chk(input [31:0] got, input [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] i, input [31:0] d, input [1:0] er);
        @(posedge clock);
        awaddr <= {i, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid_q);
        bready <= 1'b0;
        chk(bresp_q, er);
    endtask
    task rd_reg(input [15:0] i, input [1:0] er);
        @(posedge clock);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid_q);
        rready <= 1'b0;
        rd = rdata_q;
        chk(rresp_q, er);
    endtask
    task wait_line(input int k);
        n = 0;
        while (nd_u.got_q.size() < k && n < 20000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20000) mismatches++;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        test_done;
    end
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        rd_reg(`IDX_LIN, `RESP_OKAY);
        chk(rd, `RST_BYTE);
        rd_reg(`IDX_IRQ, `RESP_OKAY);
        chk(rd, `RST_BYTE);
        rd_reg(`IDX_BAUD, `RESP_OKAY);
        chk(rd, `BAUD_DIV_RST);
        rd_reg(`IDX_DATA, `RESP_OKAY);
        chk(rd, `RST_BYTE);
        rd_reg(16'h0000, `RESP_SLVERR);
        wr(16'h0000, 32'h1, `RESP_SLVERR);
        $display("test registers done");
        wr(`IDX_IRQ, 32'h1, `RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            exp_q.push_back(v);
            wr(`IDX_DATA, {24'h0, v}, `RESP_OKAY);
        end
        wait_line(1);
        chk(tx_done_irq, 1'b0);
        wait_line(3);
        repeat (20) @(posedge clock);
        repeat (3) chk(nd_u.got_q.pop_front(), exp_q.pop_front());
        rd_reg(`IDX_IRQ, `RESP_OKAY);
        chk(rd, 32'h1);
        repeat (50) @(posedge clock);
        chk(tx_done_irq, 1'b1);
        wr(`IDX_IRQ, 32'h0, `RESP_OKAY);
        chk(tx_done_irq, 1'b0);
        rd_reg(`IDX_IRQ, `RESP_OKAY);
        chk(rd, 32'h0);
        $display("test transmit done");
        for (int i = 0; i < 2; i++) begin
            v = $random(seed);
            exp_q.push_back(v);
            nd_u.tx_byte(v);
        end
        repeat (20) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            rd_reg(`IDX_DATA, `RESP_OKAY);
            chk(rd, (i < 2) ? exp_q.pop_front() : 8'h00);
        end
        $display("test receive done");
        rd_reg(`IDX_STAT, `RESP_OKAY);
        chk(rd[1:0], 2'h1);
        wr(`IDX_LIN, 32'hC0, `RESP_OKAY);
        wr(`IDX_LIN, 32'hC8, `RESP_OKAY);
        v = $random(seed);
        exp_q = '{8'h55, v};
        wr(`IDX_DATA, 32'h55, `RESP_OKAY);
        wr(`IDX_DATA, {24'h0, v}, `RESP_OKAY);
        wait_line(2);
        chk(nd_u.brk_n, 1);
        repeat (2) chk(nd_u.got_q.pop_front(), exp_q.pop_front());
        rd_reg(`IDX_STAT, `RESP_OKAY);
        chk(rd[2], 1'b1);
        v = $random(seed);
        exp_q.push_back(v);
        wr(`IDX_DATA, {24'h0, v}, `RESP_OKAY);
        wait_line(1);
        chk(nd_u.got_q.pop_front(), exp_q.pop_front());
        rd_reg(`IDX_LIN, `RESP_OKAY);
        chk(rd, 32'hC0);
        wr(`IDX_LIN, 32'h80, `RESP_OKAY);
        rd_reg(`IDX_LIN, `RESP_OKAY);
        chk(rd, 32'hC0);
        $display("test master done");
        wr(`IDX_LIN, 32'h0, `RESP_OKAY);
        wr(`IDX_BAUD, 32'h11, `RESP_OKAY);
        wr(`IDX_LIN, 32'hA0, `RESP_OKAY);
        v = $random(seed);
        nd_u.tx_header(v);
        repeat (20) @(posedge clock);
        rd_reg(`IDX_STAT, `RESP_OKAY);
        chk(rd[3], 1'b1);
        rd_reg(`IDX_BAUD, `RESP_OKAY);
        chk(rd, 32'h10);
        rd_reg(`IDX_DATA, `RESP_OKAY);
        chk(rd, {24'h0, v});
        $display("test slave done");
        test_done;
    end
endmodule
